// ===== core/sector_guard.v
// Per-sector write guard: mode select, lock flag, persistent and volatile guard bits.
// Assumes decoded instructions arrive as one-cycle strobes synchronous to core_clk.
`timescale 1ns/10ps
`include "sector_guard_consts.vh"
module sector_guard #(
    parameter ADDR_W = 25,
    parameter UNIT_W = 10,
    parameter UNITS  = 542
) (
    core_clk,
    rst_n,
    protection_scheme_select,
    write_enable_latch,
    cmd_valid,
    cmd_code,
    cmd_addr,
    cmd_data,
    op_valid,
    op_addr,
    protection_mode_select,
    guard_lock_status,
    persistent_guard_mask,
    read_data,
    read_valid,
    cmd_done,
    cmd_ignored,
    op_grant,
    op_reject,
    clear_wel
);
    input  wire                        core_clk;
    input  wire                        rst_n;
    input  wire                        protection_scheme_select;
    input  wire                        write_enable_latch;
    input  wire                        cmd_valid;
    input  wire [`CMD_WIDTH-1:0]       cmd_code;
    input  wire [ADDR_W-1:0]           cmd_addr;
    input  wire [`MODE_SEL_WIDTH-1:0]  cmd_data;
    input  wire                        op_valid;
    input  wire [ADDR_W-1:0]           op_addr;
    output reg  [`MODE_SEL_WIDTH-1:0]  protection_mode_select;
    output reg  [`LOCK_STAT_WIDTH-1:0] guard_lock_status;
    output reg                         persistent_guard_mask;
    output reg  [7:0]                  read_data;
    output reg                         read_valid;
    output reg                         cmd_done;
    output reg                         cmd_ignored;
    output reg                         op_grant;
    output reg                         op_reject;
    output reg                         clear_wel;

    // ----------------------------------------
    // Storage and unit decode
    // ----------------------------------------
    reg  [UNITS-1:0]  persistent_sector_guard_reg;
    reg  [UNITS-1:0]  volatile_sector_guard_reg;
    reg               mode_loaded_reg;
    wire [UNIT_W-1:0] cmd_unit;
    wire [UNIT_W-1:0] op_unit;

    guard_unit_index #(
        .ADDR_W (ADDR_W),
        .UNIT_W (UNIT_W)
    ) u_cmd_index (
        .addr (cmd_addr),
        .unit (cmd_unit)
    );

    guard_unit_index #(
        .ADDR_W (ADDR_W),
        .UNIT_W (UNIT_W)
    ) u_op_index (
        .addr (op_addr),
        .unit (op_unit)
    );

    // ----------------------------------------
    // Mode decode
    // ----------------------------------------
    function is_password_mode;
        input [`MODE_SEL_WIDTH-1:0] sel;
        begin
            is_password_mode = ~sel[`MODE_SEL_PWD_BIT];
        end
    endfunction

    function [7:0] guard_byte;
        input bit_value;
        begin
            guard_byte = bit_value ? `GUARD_READ_SET : `GUARD_READ_CLEAR;
        end
    endfunction

    wire password_mode = is_password_mode(protection_mode_select);
    wire lock_flag     = guard_lock_status[`LOCK_FLAG_BIT];
    wire we_ok         = cmd_valid & write_enable_latch & protection_scheme_select;
    wire rd_ok         = cmd_valid & protection_scheme_select;
    localparam [UNIT_W-1:0] UNIT_LIMIT = UNITS;
    wire [UNIT_W-1:0] unit_limit = UNIT_LIMIT;
    wire cmd_unit_ok   = cmd_unit < unit_limit;
    wire op_unit_ok    = op_unit < unit_limit;

    // ----------------------------------------
    // Mode select write check
    // ----------------------------------------
    reg                        mode_write_ok;
    reg [`MODE_SEL_WIDTH-1:0]  mode_next;
    always @* begin
        mode_next = protection_mode_select & cmd_data;
        mode_write_ok = 1'b1;
        if (~cmd_data[`MODE_SEL_SOLID_BIT] & ~cmd_data[`MODE_SEL_PWD_BIT]) begin
            mode_write_ok = 1'b0;
        end
        if (~protection_mode_select[`MODE_SEL_SOLID_BIT]) begin
            mode_next[`MODE_SEL_PWD_BIT] = protection_mode_select[`MODE_SEL_PWD_BIT];
        end
        if (~protection_mode_select[`MODE_SEL_PWD_BIT]) begin
            mode_next[`MODE_SEL_SOLID_BIT] = protection_mode_select[`MODE_SEL_SOLID_BIT];
        end
    end

    // ----------------------------------------
    // Instruction handling
    // ----------------------------------------
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            protection_mode_select      <= `MODE_SEL_RESET;
            guard_lock_status           <= `LOCK_STAT_RESET;
            persistent_guard_mask       <= 1'b1;
            persistent_sector_guard_reg <= {UNITS{1'b0}};
            volatile_sector_guard_reg   <= {UNITS{1'b1}};
            mode_loaded_reg             <= 1'b0;
            read_data                   <= 8'h00;
            read_valid                  <= 1'b0;
            cmd_done                    <= 1'b0;
            cmd_ignored                 <= 1'b0;
            clear_wel                   <= 1'b0;
        end else begin
            read_valid  <= 1'b0;
            cmd_done    <= 1'b0;
            cmd_ignored <= 1'b0;
            clear_wel   <= 1'b0;
            if (!mode_loaded_reg) begin
                mode_loaded_reg <= 1'b1;
                guard_lock_status[`LOCK_FLAG_BIT] <= ~password_mode;
            end else if (cmd_valid) begin
                cmd_done <= 1'b1;
                case (cmd_code)
                    `CMD_WRITE_MODE_SEL: begin
                        if (write_enable_latch && mode_write_ok) begin
                            protection_mode_select <= mode_next;
                            clear_wel <= 1'b1;
                            if (!password_mode && is_password_mode(mode_next)) begin
                                guard_lock_status[`LOCK_FLAG_BIT] <= 1'b0;
                            end
                        end else begin
                            cmd_ignored <= 1'b1;
                        end
                    end
                    `CMD_LOCK_CLEAR: begin
                        if (we_ok) begin
                            guard_lock_status[`LOCK_FLAG_BIT] <= 1'b0;
                            clear_wel <= 1'b1;
                        end else begin
                            cmd_ignored <= 1'b1;
                        end
                    end
                    `CMD_PWD_UNLOCK_OK: begin
                        if (we_ok && password_mode) begin
                            guard_lock_status[`LOCK_FLAG_BIT] <= 1'b1;
                            clear_wel <= 1'b1;
                        end else begin
                            cmd_ignored <= 1'b1;
                        end
                    end
                    `CMD_GUARD_PROGRAM, `CMD_GUARD_ERASE: begin
                        if (we_ok && lock_flag && (cmd_unit_ok || cmd_code == `CMD_GUARD_ERASE)) begin
                            if (cmd_code == `CMD_GUARD_ERASE) begin
                                persistent_sector_guard_reg <= {UNITS{1'b0}};
                            end else begin
                                persistent_sector_guard_reg[cmd_unit] <= 1'b1;
                            end
                            clear_wel <= 1'b1;
                        end else begin
                            cmd_ignored <= 1'b1;
                        end
                    end
                    `CMD_VOL_LOCK, `CMD_VOL_UNLOCK: begin
                        if (we_ok && cmd_unit_ok) begin
                            volatile_sector_guard_reg[cmd_unit] <= (cmd_code == `CMD_VOL_LOCK);
                            clear_wel <= 1'b1;
                        end else begin
                            cmd_ignored <= 1'b1;
                        end
                    end
                    `CMD_GLOBAL_LOCK, `CMD_GLOBAL_UNLOCK: begin
                        if (we_ok) begin
                            volatile_sector_guard_reg <= {UNITS{cmd_code == `CMD_GLOBAL_LOCK}};
                            clear_wel <= 1'b1;
                        end else begin
                            cmd_ignored <= 1'b1;
                        end
                    end
                    `CMD_MASK_SET, `CMD_MASK_CLEAR: begin
                        if (we_ok && (!password_mode || lock_flag)) begin
                            persistent_guard_mask <= (cmd_code == `CMD_MASK_SET);
                            clear_wel <= 1'b1;
                        end else begin
                            cmd_ignored <= 1'b1;
                        end
                    end
                    `CMD_READ_GUARD: begin
                        if (rd_ok && cmd_unit_ok) begin
                            read_data  <= guard_byte(persistent_sector_guard_reg[cmd_unit]);
                            read_valid <= 1'b1;
                        end else begin
                            cmd_ignored <= 1'b1;
                        end
                    end
                    `CMD_READ_VOL: begin
                        if (rd_ok && cmd_unit_ok) begin
                            read_data  <= guard_byte(volatile_sector_guard_reg[cmd_unit]);
                            read_valid <= 1'b1;
                        end else begin
                            cmd_ignored <= 1'b1;
                        end
                    end
                    `CMD_SOFT_RESET: begin
                        guard_lock_status[`LOCK_FLAG_BIT] <= ~password_mode;
                        persistent_guard_mask     <= 1'b1;
                        volatile_sector_guard_reg <= {UNITS{1'b1}};
                    end
                    default: begin
                        cmd_ignored <= 1'b1;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------
    // Program and erase protection check
    // ----------------------------------------
    wire op_protected = ~op_unit_ok |
                        volatile_sector_guard_reg[op_unit] |
                        (persistent_sector_guard_reg[op_unit] & persistent_guard_mask);

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            op_grant  <= 1'b0;
            op_reject <= 1'b0;
        end else begin
            op_grant  <= op_valid & mode_loaded_reg & ~(protection_scheme_select & op_protected);
            op_reject <= op_valid & (~mode_loaded_reg | (protection_scheme_select & op_protected));
        end
    end
endmodule // sector_guard

// ===== core/sector_guard_consts.vh
// Constants for the sector guard logic: register fields, reset values, commands, answers.
// Assumes nothing of its surroundings; included by sector_guard.
`ifndef SECTOR_GUARD_CONSTS_VH
`define SECTOR_GUARD_CONSTS_VH

// ----------------------------------------
// Register layout
// ----------------------------------------
`define MODE_SEL_WIDTH      16
`define MODE_SEL_RESET      16'hffff
`define MODE_SEL_SOLID_BIT  1
`define MODE_SEL_PWD_BIT    2
`define LOCK_STAT_WIDTH     8
`define LOCK_FLAG_BIT       0
`define LOCK_STAT_RESET     8'h00

// ----------------------------------------
// Commands
// ----------------------------------------
`define CMD_WIDTH           4
`define CMD_NOP             4'h0
`define CMD_WRITE_MODE_SEL  4'h1
`define CMD_LOCK_CLEAR      4'h2
`define CMD_PWD_UNLOCK_OK   4'h3
`define CMD_GUARD_PROGRAM   4'h4
`define CMD_GUARD_ERASE     4'h5
`define CMD_VOL_LOCK        4'h6
`define CMD_VOL_UNLOCK      4'h7
`define CMD_GLOBAL_LOCK     4'h8
`define CMD_GLOBAL_UNLOCK   4'h9
`define CMD_READ_GUARD      4'ha
`define CMD_READ_VOL        4'hb
`define CMD_MASK_SET        4'hc
`define CMD_MASK_CLEAR      4'hd
`define CMD_SOFT_RESET      4'he

// ----------------------------------------
// Read answers
// ----------------------------------------
`define GUARD_READ_CLEAR    8'h00
`define GUARD_READ_SET      8'hff

`endif

// ===== core/guard_unit_index.v
// Maps a byte address to a protection unit index.
// Assumes 4KB sectors in the bottom and top 64KB and 64KB blocks between.
`timescale 1ns/10ps
module guard_unit_index #(
    parameter ADDR_W  = 25,
    parameter UNIT_W  = 10
) (
    addr,
    unit
);
    input  wire [ADDR_W-1:0] addr;
    output reg  [UNIT_W-1:0] unit;

    localparam BLOCKS = 1 << (ADDR_W - 16);
    localparam PAD_W  = UNIT_W - (ADDR_W - 16);
    localparam [UNIT_W-1:0] TOP_BASE = BLOCKS + 14;
    localparam [UNIT_W-1:0] MID_BASE = 15;

    // ----------------------------------------
    // Unit numbering: 0-15 bottom sectors, 16-(16+BLOCKS-3) middle, then top sectors.
    // ----------------------------------------
    always @* begin
        if (addr[ADDR_W-1:16] == {(ADDR_W-16){1'b0}}) begin
            unit = {{(UNIT_W-4){1'b0}}, addr[15:12]};
        end else if (addr[ADDR_W-1:16] == {(ADDR_W-16){1'b1}}) begin
            unit = TOP_BASE + {{(UNIT_W-4){1'b0}}, addr[15:12]};
        end else begin
            unit = MID_BASE + {{PAD_W{1'b0}}, addr[ADDR_W-1:16]};
        end
    end
endmodule // guard_unit_index

// ===== verification/sector_guard_properties.sv
// Checker for sector_guard: answer pulses, mode select and lock flag.
// Assumes the bind below and the port names of sector_guard.
`timescale 1ns/10ps
module sector_guard_chk (
    input wire        core_clk,
    input wire        rst_n,
    input wire        protection_scheme_select,
    input wire        write_enable_latch,
    input wire        cmd_valid,
    input wire [3:0]  cmd_code,
    input wire        op_valid,
    input wire [15:0] protection_mode_select,
    input wire [7:0]  guard_lock_status,
    input wire        cmd_done,
    input wire        cmd_ignored,
    input wire        read_valid,
    input wire        clear_wel,
    input wire        op_grant,
    input wire        op_reject
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    property p_cmd_answer;
        cmd_valid |=> cmd_done && !(cmd_ignored && clear_wel);
    endproperty
    a_cmd_answer: assert property (p_cmd_answer) else $error("bad cmd answer");
    property p_cmd_quiet;
        !cmd_valid |=> !cmd_done && !cmd_ignored && !read_valid && !clear_wel;
    endproperty
    a_cmd_quiet: assert property (p_cmd_quiet) else $error("answer without command");
    property p_lock_rise;
        $rose(guard_lock_status[0]) && $past(rst_n, 2)
            |-> $past(cmd_valid) && ($past(cmd_code) == 4'h3 || $past(cmd_code) == 4'he);
    endproperty
    a_lock_rise: assert property (p_lock_rise) else $error("lock set without unlock");
    property p_op_answer;
        op_valid |=> op_grant != op_reject;
    endproperty
    a_op_answer: assert property (p_op_answer) else $error("bad op answer");
    property p_mode_otp;
        (protection_mode_select & ~$past(protection_mode_select)) == 16'h0000;
    endproperty
    a_mode_otp: assert property (p_mode_otp) else $error("mode bit rose");
    property p_mode_excl;
        protection_mode_select[2] || protection_mode_select[1];
    endproperty
    a_mode_excl: assert property (p_mode_excl) else $error("both mode bits low");
    property p_stat_rsvd;
        guard_lock_status[7:1] == 7'h00;
    endproperty
    a_stat_rsvd: assert property (p_stat_rsvd) else $error("status reserved set");
    property p_pwd_entry;
        $fell(protection_mode_select[2]) |-> !guard_lock_status[0];
    endproperty
    a_pwd_entry: assert property (p_pwd_entry) else $error("lock kept on entry");
    property p_locked_prog;
        cmd_valid && cmd_code == 4'h4 && !guard_lock_status[0] |=> cmd_ignored;
    endproperty
    a_locked_prog: assert property (p_locked_prog) else $error("locked program taken");
    property p_lock_clear;
        cmd_valid && cmd_code == 4'h2 && write_enable_latch && protection_scheme_select
            |=> cmd_done && !guard_lock_status[0];
    endproperty
    a_lock_clear: assert property (p_lock_clear) else $error("lock not cleared");
endmodule // sector_guard_chk
bind sector_guard sector_guard_chk i_chk (.*);

// ===== verification/flash_host_model.sv
// Host controller model: issues decoded instructions and program/erase requests.
// Assumes the guard block samples its inputs on the rising edge of core_clk.
`timescale 1ns/10ps
module flash_host_model (
    input  logic        core_clk,
    input  logic        clear_wel,
    output logic        protection_scheme_select = 1'b1,
    output logic        write_enable_latch = 1'b0,
    output logic        cmd_valid = 1'b0,
    output logic [3:0]  cmd_code = 4'h0,
    output logic [24:0] cmd_addr = 25'h0,
    output logic [15:0] cmd_data = 16'h0,
    output logic        op_valid = 1'b0,
    output logic [24:0] op_addr = 25'h0
);
    task automatic issue(input logic [3:0] c, input logic [24:0] a, input logic [15:0] d,
                         input bit w, input bit s);
        @(posedge core_clk);
        #1;
        write_enable_latch = w;
        protection_scheme_select = s;
        @(posedge core_clk);
        #1;
        cmd_valid = 1'b1;
        cmd_code = c;
        cmd_addr = a;
        cmd_data = d;
        @(posedge core_clk);
        #1;
        cmd_valid = 1'b0;
        cmd_addr = ~a;
        cmd_data = ~d;
        if (clear_wel)
            write_enable_latch = 1'b0;
    endtask
    task automatic request(input logic [24:0] a);
        @(posedge core_clk);
        #1;
        op_valid = 1'b1;
        op_addr = a;
        @(posedge core_clk);
        #1;
        op_valid = 1'b0;
        op_addr = ~a;
    endtask
endmodule // flash_host_model

// ===== verification/sector_guard_tb.sv
// Testbench for sector_guard: host model stimulus checked against a reference model.
// Assumes sector_guard, flash_host_model and the checker are compiled first.
`timescale 1ns/10ps
module sector_guard_tb;
    logic        core_clk = 1'b0;
    logic        rst_n = 1'b0;
    wire         protection_scheme_select, write_enable_latch, cmd_valid, op_valid;
    wire  [3:0]  cmd_code;
    wire  [24:0] cmd_addr, op_addr;
    wire  [15:0] cmd_data, protection_mode_select;
    wire  [7:0]  guard_lock_status, read_data;
    wire         persistent_guard_mask, read_valid, cmd_done, cmd_ignored;
    wire         op_grant, op_reject, clear_wel;
    int          fails = 0;
    int          n_checks = 0;
    int          seed = 32'h5daa;
    logic [15:0] mode = 16'hffff;
    bit          lock = 1'b1;
    bit          mask = 1'b1;
    bit          pers[542];
    bit          vol[542] = '{default: 1'b1};
    logic [3:0]  rc;
    logic [24:0] ra;
    logic [24:0] addrs[8] = '{25'h0, 25'hfff, 25'hf000, 25'h10000, 25'h123456, 25'h1feffff,
                              25'h1ff0000, 25'h1ffffff};
    always #20 core_clk = ~core_clk;
    sector_guard i_dut (.*);
    flash_host_model i_host (.*);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic hw_reset();
        rst_n = 1'b0;
        repeat (16) @(posedge core_clk);
        #1;
        rst_n = 1'b1;
        mode = 16'hffff;
        lock = 1'b1;
        mask = 1'b1;
        vol = '{default: 1'b1};
        pers = '{default: 1'b0};
    endtask
    task automatic send(input logic [3:0] c, input logic [24:0] a, input logic [15:0] d,
                        input bit w, input bit s);
        int         u;
        bit         ok;
        bit         p;
        logic [7:0] rd;
        logic [15:0] nm;
        u = a < 25'h10000 ? a[15:12] : a >= 25'h1ff0000 ? 526 + a[15:12] : 15 + a[24:16];
        ok = s && (w || c == 4'ha || c == 4'hb);
        case (c)
            4'h1: ok = w && (d[2] || d[1]);
            4'h3: ok = ok && !mode[2];
            4'h4, 4'h5: ok = ok && lock;
            4'hc, 4'hd: ok = ok && (mode[2] || lock);
            4'he: ok = 1'b1;
            default: ;
        endcase
        rd = (c == 4'ha ? pers[u] : vol[u]) ? 8'hff : 8'h00;
        if (ok) begin
            case (c)
                4'h1: begin
                    nm = mode & d;
                    if (!mode[1]) nm[2] = mode[2];
                    if (!mode[2]) nm[1] = mode[1];
                    if (mode[2] && !nm[2]) lock = 1'b0;
                    mode = nm;
                end
                4'h2: lock = 1'b0;
                4'h3: lock = 1'b1;
                4'h4: pers[u] = 1'b1;
                4'h5: pers = '{default: 1'b0};
                4'h6, 4'h7: vol[u] = c == 4'h6;
                4'h8, 4'h9: vol = '{default: c == 4'h8};
                4'hc, 4'hd: mask = c == 4'hc;
                4'he: begin
                    lock = mode[2];
                    mask = 1'b1;
                    vol = '{default: 1'b1};
                end
                default: ;
            endcase
        end
        i_host.issue(c, a, d, w, s);
        chk({cmd_done, cmd_ignored}, {1'b1, !ok});
        chk(clear_wel, ok && !(c inside {4'ha, 4'hb, 4'he}));
        chk(read_valid, ok && (c == 4'ha || c == 4'hb));
        if (ok && (c == 4'ha || c == 4'hb))
            chk({read_valid, read_data}, {1'b1, rd});
        chk({protection_mode_select, guard_lock_status}, {mode, 7'h00, lock});
        chk(persistent_guard_mask, mask);
        p = s && (vol[u] || (pers[u] && mask));
        i_host.request(a);
        chk({op_grant, op_reject}, {!p, p});
    endtask
    initial begin
        #400000;
        fails++;
        end_of_test();
    end
    initial begin
        hw_reset();
        foreach (addrs[i]) begin
            send(4'ha, addrs[i], 0, 0, 1);
            send(4'hb, addrs[i], 0, 0, 1);
        end
        $display("test reset_state done");
        send(4'h5, 0, 0, 1, 0);
        send(4'h9, 0, 0, 0, 1);
        send(4'h9, 0, 0, 1, 1);
        send(4'h4, 25'h1fff000, 0, 1, 1);
        send(4'hd, 25'h1fff000, 0, 1, 1);
        send(4'hc, 25'h1fff000, 0, 1, 1);
        send(4'h6, 25'h10000, 0, 1, 1);
        send(4'h2, 0, 0, 1, 1);
        send(4'h4, 0, 0, 1, 1);
        send(4'he, 0, 0, 1, 1);
        send(4'h5, 0, 0, 1, 1);
        $display("test guard_bits done");
        send(4'h1, 0, 16'hfff9, 1, 1);
        send(4'h1, 0, 16'hfffd, 1, 1);
        send(4'h1, 0, 16'hfffb, 1, 1);
        hw_reset();
        send(4'h1, 0, 16'hfffb, 0, 1);
        send(4'h1, 0, 16'hfffb, 1, 1);
        send(4'hd, 0, 0, 1, 1);
        send(4'h4, 0, 0, 1, 1);
        send(4'h3, 0, 0, 1, 1);
        send(4'h4, 0, 0, 1, 1);
        send(4'he, 0, 0, 1, 1);
        $display("test modes done");
        repeat (300) begin
            rc = 4'h1 + 4'(($random(seed) & 32'hff) % 14);
            ra = seed[0] ? addrs[seed[3:1]] : 25'($random(seed));
            send(rc, ra, 16'($random(seed)), rc inside {4'h3, [4'hc:4'he]} || $random(seed) % 4 != 0,
                 rc == 4'he || $random(seed) % 8 != 0);
        end
        $display("test random done");
        end_of_test();
    end
endmodule // sector_guard_tb
